// file: verilog/rtl_tracking_loops.sv
// Decided for this implementation: register access over APB and the address map.
module rtl_tracking_loops (
  input wire logic clk_i, // 50 MHz clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [3:0] peak_i, // Demod sample magnitude
  input wire logic signed [11:0] freq_i, // Instant frequency sample
  input wire logic rssi_above_i, // RSSI threshold level, async
  input wire logic sync_det_i, // Sync detect pulse, same clock
  input wire logic bit_edge_i, // Received bit edge, same clock
  input wire logic [15:0] nom_period_i, // Nominal symbol period
  output logic [3:0] atten_o, // RF attenuation steps of 6 dB
  output logic signed [11:0] freq_corr_o, // Frequency correction
  output logic sym_stb_o // Local symbol strobe
);
  // Configuration registers
  logic [31:0] gain_ctrl_q, gain_threshold_cfg_q, gain_window_cfg_q;
  logic [31:0] freq_cfg_q, timing_loop_cfg_q;
  // Decoded fields
  logic gain_loop_on;
  logic [3:0] thr_hi, thr_lo, peak_window_exponent;
  logic fc_on, freq_comp_hold_at_sync, sync_used;
  logic [1:0] mod_sel;
  logic [3:0] freq_comp_initial_gain, freq_comp_tracking_gain;
  logic [3:0] freq_peak_leak;
  logic [7:0] freq_comp_initial_symbols;
  logic timing_loop_order_sel;
  logic [2:0] timing_prop_gain;
  logic [3:0] timing_integral_gain;

  assign gain_loop_on = gain_ctrl_q[rtl_pkg::RTL_GAIN_ON_BIT];
  assign thr_hi = gain_threshold_cfg_q[rtl_pkg::RTL_THR_HI_LSB +: 4];
  assign thr_lo = gain_threshold_cfg_q[rtl_pkg::RTL_THR_LO_LSB +: 4];
  assign peak_window_exponent =
    gain_window_cfg_q[rtl_pkg::RTL_WIN_EXP_LSB +: 4];
  assign fc_on = freq_cfg_q[rtl_pkg::RTL_FC_ON_BIT];
  assign freq_comp_hold_at_sync = freq_cfg_q[rtl_pkg::RTL_FC_HOLD_BIT];
  assign sync_used = freq_cfg_q[rtl_pkg::RTL_FC_SYNC_USED_BIT];
  assign mod_sel = freq_cfg_q[rtl_pkg::RTL_FC_MOD_LSB +: 2];
  assign freq_comp_initial_gain = freq_cfg_q[rtl_pkg::RTL_FC_IGAIN_LSB +: 4];
  assign freq_comp_tracking_gain =
    freq_cfg_q[rtl_pkg::RTL_FC_TGAIN_LSB +: 4];
  assign freq_peak_leak = freq_cfg_q[rtl_pkg::RTL_FC_LEAK_LSB +: 4];
  assign freq_comp_initial_symbols =
    freq_cfg_q[rtl_pkg::RTL_FC_SYMS_LSB +: 8];
  assign timing_loop_order_sel =
    timing_loop_cfg_q[rtl_pkg::RTL_TL_ORDER_BIT];
  assign timing_prop_gain = timing_loop_cfg_q[rtl_pkg::RTL_TL_PGAIN_LSB +: 3];
  assign timing_integral_gain =
    timing_loop_cfg_q[rtl_pkg::RTL_TL_IGAIN_LSB +: 4];

  // APB decode; zero wait states, unmapped address answers slverr
  logic acc, wr;
  logic hit_gctl, hit_thr, hit_win, hit_fc, hit_tl;
  logic hit_st, hit_fe, hit_te, hit_any;
  assign acc = psel && penable;
  assign hit_gctl = (paddr == rtl_pkg::RTL_GAIN_CTRL_OFS);
  assign hit_thr = (paddr == rtl_pkg::RTL_GAIN_THR_OFS);
  assign hit_win = (paddr == rtl_pkg::RTL_GAIN_WIN_OFS);
  assign hit_fc = (paddr == rtl_pkg::RTL_FREQ_CFG_OFS);
  assign hit_tl = (paddr == rtl_pkg::RTL_TIMING_CFG_OFS);
  assign hit_st = (paddr == rtl_pkg::RTL_STATUS_OFS);
  assign hit_fe = (paddr == rtl_pkg::RTL_FREQ_EST_OFS);
  assign hit_te = (paddr == rtl_pkg::RTL_TIMING_EST_OFS);
  assign hit_any = hit_gctl | hit_thr | hit_win | hit_fc | hit_tl |
                   hit_st | hit_fe | hit_te;
  assign wr = acc && pwrite && hit_any;
  assign pready = 1'b1;
  assign pslverr = acc && !hit_any;

  // Register writes; 4-bit fields hold the full 0..15 range
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gain_ctrl_q <= rtl_pkg::RTL_GAIN_CTRL_RST;
      gain_threshold_cfg_q <= rtl_pkg::RTL_GAIN_THR_RST;
      gain_window_cfg_q <= rtl_pkg::RTL_GAIN_WIN_RST;
      freq_cfg_q <= rtl_pkg::RTL_FREQ_CFG_RST;
      timing_loop_cfg_q <= rtl_pkg::RTL_TIMING_CFG_RST;
    end else if (wr) begin
      if (hit_gctl) gain_ctrl_q <= {31'h0, pwdata[0]};
      if (hit_thr) gain_threshold_cfg_q <= {24'h0, pwdata[7:0]};
      if (hit_win) gain_window_cfg_q <= {28'h0, pwdata[3:0]};
      if (hit_fc) freq_cfg_q <= {4'h0, pwdata[27:8], 2'h0, pwdata[5:4],
                                 1'b0, pwdata[2:0]};
      if (hit_tl) timing_loop_cfg_q <= {23'h0, pwdata[8:4], 1'b0,
                                        pwdata[2:0]};
    end
  end
  // lower threshold shares the threshold write above

  // Gain loop
  logic win_end;
  rtl_gain_loop u_gain (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .on_i(gain_loop_on),
    .thr_hi_i(thr_hi),
    .thr_lo_i(thr_lo),
    .win_exp_i(peak_window_exponent),
    .peak_i(peak_i),
    .atten_o(atten_o),
    .win_end_o(win_end)
  );

  // Timing loop
  logic [15:0] period_est;
  rtl_timing_loop u_timing (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .order_sel_i(timing_loop_order_sel),
    .pgain_i(timing_prop_gain),
    .igain_i(timing_integral_gain),
    .nom_period_i(nom_period_i),
    .bit_edge_i(bit_edge_i),
    .sym_stb_o(sym_stb_o),
    .period_o(period_est)
  );

  // RSSI level arrives from the analog side: two-stage synchroniser
  logic rssi_s1_q, rssi_s2_q, rssi_s3_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rssi_s1_q <= 1'b0;
      rssi_s2_q <= 1'b0;
      rssi_s3_q <= 1'b0;
    end else begin
      rssi_s1_q <= rssi_above_i;
      rssi_s2_q <= rssi_s1_q;
      rssi_s3_q <= rssi_s2_q;
    end
  end
  logic rssi_rise;
  assign rssi_rise = rssi_s2_q && !rssi_s3_q;

  // Frequency compensation allowed only for FSK family
  logic fc_allowed;
  assign fc_allowed = fc_on && (mod_sel != rtl_pkg::RTL_MOD_ASK);

  // Phase sequencer: idle, fast, slow, frozen
  rtl_pkg::rtl_fc_state_t st_q, st_d;
  logic [7:0] sym_cnt_q, sym_cnt_d;
  logic fast_done;
  assign fast_done = sym_stb_o &&
                     (sym_cnt_q >= freq_comp_initial_symbols - 8'h1);
  always_comb begin
    st_d = st_q;
    case (st_q)
      rtl_pkg::RTL_FC_IDLE: begin
        if (rssi_rise) st_d = rtl_pkg::RTL_FC_FAST;
      end
      rtl_pkg::RTL_FC_FAST: begin
        if (fast_done || freq_comp_initial_symbols == 8'h0) begin
          st_d = rtl_pkg::RTL_FC_SLOW;
        end
      end
      rtl_pkg::RTL_FC_SLOW: begin
        if (sync_det_i && sync_used && freq_comp_hold_at_sync) begin
          st_d = rtl_pkg::RTL_FC_FROZEN;
        end
      end
      default: st_d = st_q;
    endcase
    if (!fc_allowed || !rssi_s2_q) st_d = rtl_pkg::RTL_FC_IDLE;
  end
  assign sym_cnt_d = (st_q != rtl_pkg::RTL_FC_FAST) ? 8'h0 :
                     sym_stb_o ? sym_cnt_q + 8'h1 : sym_cnt_q;

  // Peak detector with leak; larger leak decays slower
  logic signed [15:0] pk_hi_q, pk_lo_q, pk_hi_d, pk_lo_d;
  logic signed [15:0] fext;
  assign fext = 16'(freq_i) <<< 4;
  assign pk_hi_d = (fext > pk_hi_q) ? fext :
                   pk_hi_q - (pk_hi_q >>> freq_peak_leak);
  assign pk_lo_d = (fext < pk_lo_q) ? fext :
                   pk_lo_q - (pk_lo_q >>> freq_peak_leak);

  // Centre estimate and correction update with phase-dependent gain
  logic signed [16:0] centre;
  logic signed [15:0] corr_q, corr_d, step;
  logic [3:0] gain_sel;
  logic adapt;
  assign centre = (17'(pk_hi_q) + 17'(pk_lo_q)) >>> 1;
  assign gain_sel = (st_q == rtl_pkg::RTL_FC_FAST) ?
                    freq_comp_initial_gain : freq_comp_tracking_gain;
  assign adapt = (st_q == rtl_pkg::RTL_FC_FAST ||
                  st_q == rtl_pkg::RTL_FC_SLOW) && sym_stb_o;
  assign step = 16'(centre >>> gain_sel);
  assign corr_d = !fc_allowed ? 16'sh0 : adapt ? corr_q + step : corr_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= rtl_pkg::RTL_FC_IDLE;
      sym_cnt_q <= 8'h0;
      pk_hi_q <= 16'sh0;
      pk_lo_q <= 16'sh0;
      corr_q <= 16'sh0;
    end else begin
      st_q <= st_d;
      sym_cnt_q <= sym_cnt_d;
      pk_hi_q <= pk_hi_d;
      pk_lo_q <= pk_lo_d;
      corr_q <= corr_d;
    end
  end
  assign freq_corr_o = corr_q[15:4];

  // Status and estimate readback
  logic [31:0] status;
  logic [31:0] rd_mux;
  assign status = {22'h0, st_q, 3'h0, win_end, atten_o};
  assign rd_mux = hit_gctl ? gain_ctrl_q :
                  hit_thr ? gain_threshold_cfg_q :
                  hit_win ? gain_window_cfg_q :
                  hit_fc ? freq_cfg_q :
                  hit_tl ? timing_loop_cfg_q :
                  hit_st ? status :
                  hit_fe ? {{16{corr_q[15]}}, corr_q} :
                  hit_te ? {16'h0, period_est} : 32'h0;
  assign prdata = (acc && !pwrite) ? rd_mux : 32'h0;
endmodule : rtl_tracking_loops

// file: verilog/rtl_pkg.sv
package rtl_pkg;
  // APB register byte offsets
  localparam logic [7:0] RTL_GAIN_CTRL_OFS = 8'h00;
  localparam logic [7:0] RTL_GAIN_THR_OFS = 8'h04;
  localparam logic [7:0] RTL_GAIN_WIN_OFS = 8'h08;
  localparam logic [7:0] RTL_FREQ_CFG_OFS = 8'h0c;
  localparam logic [7:0] RTL_TIMING_CFG_OFS = 8'h10;
  localparam logic [7:0] RTL_STATUS_OFS = 8'h14;
  localparam logic [7:0] RTL_FREQ_EST_OFS = 8'h18;
  localparam logic [7:0] RTL_TIMING_EST_OFS = 8'h1c;
  // Gain control fields
  localparam int RTL_GAIN_ON_BIT = 0;
  localparam int RTL_THR_LO_LSB = 0;
  localparam int RTL_THR_HI_LSB = 4;
  localparam int RTL_WIN_EXP_LSB = 0;
  // Frequency compensation fields
  localparam int RTL_FC_ON_BIT = 0;
  localparam int RTL_FC_HOLD_BIT = 1;
  localparam int RTL_FC_SYNC_USED_BIT = 2;
  localparam int RTL_FC_MOD_LSB = 4;
  localparam int RTL_FC_IGAIN_LSB = 8;
  localparam int RTL_FC_TGAIN_LSB = 12;
  localparam int RTL_FC_LEAK_LSB = 16;
  localparam int RTL_FC_SYMS_LSB = 20;
  // Timing loop fields
  localparam int RTL_TL_PGAIN_LSB = 0;
  localparam int RTL_TL_IGAIN_LSB = 4;
  localparam int RTL_TL_ORDER_BIT = 8;
  // Reset values
  localparam logic [31:0] RTL_GAIN_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] RTL_GAIN_THR_RST = 32'h0000_00c4;
  localparam logic [31:0] RTL_GAIN_WIN_RST = 32'h0000_0002;
  localparam logic [31:0] RTL_FREQ_CFG_RST = 32'h0081_5430;
  localparam logic [31:0] RTL_TIMING_CFG_RST = 32'h0000_0082;
  // Gain step size and limits
  localparam int RTL_ATTEN_STEP_DB = 6;
  localparam int RTL_ATTEN_MAX_DB = 48;
  localparam logic [3:0] RTL_ATTEN_MAX_STEPS =
    4'(RTL_ATTEN_MAX_DB / RTL_ATTEN_STEP_DB);
  localparam int RTL_WIN_BASE_CYCLES = 12;
  // Modulation codes for frequency compensation
  localparam logic [1:0] RTL_MOD_FSK = 2'h0;
  localparam logic [1:0] RTL_MOD_GFSK = 2'h1;
  localparam logic [1:0] RTL_MOD_MSK = 2'h2;
  localparam logic [1:0] RTL_MOD_ASK = 2'h3;
  // Frequency compensation phases
  typedef enum logic [1:0] {
    RTL_FC_IDLE = 2'b00,
    RTL_FC_FAST = 2'b01,
    RTL_FC_SLOW = 2'b11,
    RTL_FC_FROZEN = 2'b10
  } rtl_fc_state_t;
endpackage : rtl_pkg

// file: verilog/rtl_gain_loop.sv
// Peak gain control: one 6 dB step per measurement window
module rtl_gain_loop (
  input wire logic clk_i, // 50 MHz clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic on_i, // Gain loop enable
  input wire logic [3:0] thr_hi_i, // Upper peak threshold
  input wire logic [3:0] thr_lo_i, // Lower peak threshold
  input wire logic [3:0] win_exp_i, // Window exponent
  input wire logic [3:0] peak_i, // Sample magnitude
  output logic [3:0] atten_o, // Attenuation in 6 dB steps
  output logic win_end_o // Window end pulse
);
  logic [19:0] cnt_q, cnt_d;
  logic [3:0] peak_q, peak_d;
  logic [3:0] atten_q, atten_d;
  logic [19:0] win_len;
  logic last;
  logic go_up, go_dn;

  // Window = 12 clocks times 2^exp
  assign win_len = 20'(rtl_pkg::RTL_WIN_BASE_CYCLES) << win_exp_i;
  assign last = (cnt_q >= win_len - 20'h1);
  assign cnt_d = (!on_i || last) ? 20'h0 : cnt_q + 20'h1;
  assign peak_d = (!on_i || last) ? 4'h0 :
                  (peak_i > peak_q ? peak_i : peak_q);
  // Step decisions; clamped at the range ends
  assign go_up = last && (peak_q > thr_hi_i) &&
                 (atten_q < rtl_pkg::RTL_ATTEN_MAX_STEPS);
  assign go_dn = last && (peak_q < thr_lo_i) &&
                 (atten_q != 4'h0);
  // Single 6 dB steps only, max 48 dB frozen when off
  assign atten_d = !on_i ? atten_q :
                   go_up ? atten_q + 4'h1 :
                   go_dn ? atten_q - 4'h1 : atten_q;

  // Window state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 20'h0;
      peak_q <= 4'h0;
      atten_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
      peak_q <= peak_d;
      atten_q <= atten_d;
    end
  end

  assign atten_o = atten_q;
  assign win_end_o = on_i && last;
endmodule : rtl_gain_loop

// file: verilog/rtl_timing_loop.sv
// Symbol timing recovery, first or second order
module rtl_timing_loop (
  input wire logic clk_i, // 50 MHz clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic order_sel_i, // 0 delay loop, 1 phase loop
  input wire logic [2:0] pgain_i, // Proportional gain shift
  input wire logic [3:0] igain_i, // Integral gain shift
  input wire logic [15:0] nom_period_i, // Nominal symbol period
  input wire logic bit_edge_i, // Received bit edge pulse
  output logic sym_stb_o, // Local symbol strobe
  output logic [15:0] period_o // Current period estimate
);
  logic [15:0] phase_q, phase_d;
  logic signed [23:0] freq_q, freq_d;
  logic [15:0] period;
  logic signed [16:0] err;
  logic signed [16:0] pcorr;
  logic signed [23:0] icorr;
  logic wrap;

  // Period: nominal plus integrated frequency term
  assign period = order_sel_i ?
    16'($signed({1'b0, nom_period_i}) + 17'(freq_q >>> 8)) : nom_period_i;
  assign wrap = (phase_q >= period - 16'h1);
  // Phase error: edge expected at half period
  assign err = $signed({1'b0, phase_q}) - $signed({2'b0, period[15:1]});
  // Smaller gain value = larger correction, faster loop
  assign pcorr = err >>> pgain_i;
  assign icorr = 24'(err) <<< 4 >>> igain_i;
  // Delay correction on each edge keeps local edges aligned
  assign phase_d = bit_edge_i ? 16'($signed({1'b0, phase_q}) - pcorr) :
                   wrap ? 16'h0 : phase_q + 16'h1;
  // Integrator only in second order mode; holds between edges so long
  // runs without transitions keep the learned period
  assign freq_d = (order_sel_i && bit_edge_i) ? freq_q + icorr :
                  order_sel_i ? freq_q : 24'sh0;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= 16'h0;
      freq_q <= 24'sh0;
      sym_stb_o <= 1'b0;
      period_o <= 16'h0;
    end else begin
      phase_q <= phase_d;
      freq_q <= freq_d;
      sym_stb_o <= wrap && !bit_edge_i;
      period_o <= period;
    end
  end
endmodule : rtl_timing_loop

// file: verif/rtl_tracking_loops_monitor.sv
module rtl_tracking_loops_monitor (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic rssi_above_i, // RSSI level
  input wire logic [3:0] atten_o, // Attenuation steps
  input wire logic signed [11:0] freq_corr_o, // Correction
  input wire logic sym_stb_o // Symbol strobe
);
  logic gain_on_q;
  logic fc_off_q;
  logic wr_acc;
  // Shadow enables, so a frozen loop can be judged
  assign wr_acc = psel && penable && pwrite;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gain_on_q <= 1'b0;
      fc_off_q <= 1'b1;
    end else if (wr_acc && paddr == rtl_pkg::RTL_GAIN_CTRL_OFS) begin
      gain_on_q <= pwdata[0];
    end else if (wr_acc && paddr == rtl_pkg::RTL_FREQ_CFG_OFS) begin
      fc_off_q <= !pwdata[0] || pwdata[5:4] == rtl_pkg::RTL_MOD_ASK;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_atten_max;
    atten_o <= 4'h8;
  endproperty
  a_atten_max: assert property (p_atten_max)
    else $error("atten high");
  property p_atten_step;
    $changed(atten_o) |-> atten_o == $past(atten_o) + 4'h1 ||
      atten_o + 4'h1 == $past(atten_o);
  endproperty
  a_atten_step: assert property (p_atten_step)
    else $error("atten jump");
  property p_gain_off;
    !gain_on_q |=> $stable(atten_o);
  endproperty
  a_gain_off: assert property (p_gain_off)
    else $error("atten moved");
  // Correction is held, not cleared, while the carrier is gone
  property p_fc_idle;
    (!rssi_above_i) [*6] |=> $stable(freq_corr_o) ||
      freq_corr_o == 12'sh000;
  endproperty
  a_fc_idle: assert property (p_fc_idle)
    else $error("corr no rssi");
  property p_fc_off;
    fc_off_q [*4] |-> freq_corr_o == 12'sh000;
  endproperty
  a_fc_off: assert property (p_fc_off)
    else $error("corr when off");
  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("wait state");
  property p_unmapped;
    psel && penable && paddr > 8'h1c |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("no slverr");
  property p_rdata_idle;
    !(psel && penable) |-> prdata == 32'h0000_0000 && !pslverr;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("bus busy");
  c_max: cover property (atten_o == 4'h8);
  c_stb: cover property (sym_stb_o);
  c_corr: cover property (freq_corr_o != 12'sh000);
  c_err: cover property (pslverr);
endmodule : rtl_tracking_loops_monitor

bind rtl_tracking_loops rtl_tracking_loops_monitor i_mon (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rssi_above_i(rssi_above_i), .atten_o(atten_o),
  .freq_corr_o(freq_corr_o), .sym_stb_o(sym_stb_o));

// file: verif/rtl_rf_model.sv
module rtl_rf_model (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic [3:0] atten_i, // Attenuation steps
  input wire logic [4:0] lvl_i, // Level before attenuation
  input wire logic rx_i, // Carrier present
  input wire logic [7:0] ep_i, // Bit edge spacing, 0 none
  output logic [3:0] peak_o, // Demod magnitude
  output logic signed [11:0] freq_o, // Frequency sample
  output logic rssi_o, // RSSI above threshold
  output logic edge_o // Bit edge pulse
);
  logic [7:0] cnt_q;
  logic [4:0] net;
  // Each step takes one unit off; the demod saturates at 15
  assign net = (lvl_i > 5'(atten_i)) ? lvl_i - 5'(atten_i) : 5'h00;
  // Magnitude follows attenuation at once, so no stale sample
  // from before a step leaks into the next window
  assign peak_o = (net > 5'h0f) ? 4'hf : net[3:0];
  // Sampled front end; noise wanders while no carrier
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 8'h00;
      freq_o <= 12'sh000;
      rssi_o <= 1'b0;
      edge_o <= 1'b0;
    end else begin
      cnt_q <= (cnt_q + 8'h01 >= ep_i && ep_i != 8'h00) ? 8'h00 :
        cnt_q + 8'h01;
      edge_o <= ep_i != 8'h00 && cnt_q == 8'h00;
      freq_o <= rx_i ? 12'sh0c0 : {cnt_q, ~cnt_q[3:0]};
      rssi_o <= rx_i;
    end
  end
endmodule : rtl_rf_model

// file: verif/tb_rtl_tracking_loops.sv
module tb_rtl_tracking_loops;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(n, x, g) begin cmp_count++; if ((g) !== (x)) begin fails++; \
  $display("[ERR] %s exp %0h got %0h", n, x, g); end end
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sync_det_i = 1'b0;
  logic [15:0] nom_period_i = 16'h0010;
  logic [4:0] lvl = 5'h00;
  logic rx = 1'b0;
  logic [7:0] ep = 8'h10;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, rssi_above_i, bit_edge_i, sym_stb_o;
  logic [3:0] peak_i, atten_o;
  logic signed [11:0] freq_i, freq_corr_o;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int g;
  rtl_tracking_loops i_rtl_tracking_loops (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .peak_i(peak_i), .freq_i(freq_i), .rssi_above_i(rssi_above_i),
    .sync_det_i(sync_det_i), .bit_edge_i(bit_edge_i),
    .nom_period_i(nom_period_i), .atten_o(atten_o),
    .freq_corr_o(freq_corr_o), .sym_stb_o(sym_stb_o));
  rtl_rf_model i_rtl_rf_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .atten_i(atten_o), .lvl_i(lvl), .rx_i(rx), .ep_i(ep), .peak_o(peak_i),
    .freq_o(freq_i), .rssi_o(rssi_above_i), .edge_o(bit_edge_i));
  always #10 clk_i = ~clk_i;
  // Cycle count doubles as the hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  // One APB transfer; request held until pready is seen
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    // Ends once pready is seen; the bench timeout ends it if pready never comes
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task automatic rdm(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] x);
    apb(a, 1'b0, 32'h0);
    `CHK("rdata", x, q & m)
  endtask : rdm
  task automatic tick(input int k);
    repeat (k) @(negedge clk_i);
  endtask : tick
  // Cycles between the next two attenuation moves
  task automatic agap(output int gg);
    int t0;
    logic [3:0] v;
    for (int i = 0; i < 2; i++) begin
      v = atten_o;
      t0 = cyc;
      while (atten_o === v && cyc - t0 < 2000) @(negedge clk_i);
    end
    gg = cyc - t0;
  endtask : agap
  task automatic strobes(input int k);
    repeat (k) begin
      @(negedge clk_i);
      for (int n = 0; sym_stb_o !== 1'b1 && n < 500; n++) @(negedge clk_i);
    end
  endtask : strobes
  task automatic sync_pulse();
    @(posedge clk_i);
    sync_det_i <= 1'b1;
    @(posedge clk_i);
    sync_det_i <= 1'b0;
    tick(3);
  endtask : sync_pulse
  initial begin
    logic [31:0] cf [2];
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rdm(rtl_pkg::RTL_GAIN_CTRL_OFS, '1, rtl_pkg::RTL_GAIN_CTRL_RST);
    rdm(rtl_pkg::RTL_GAIN_THR_OFS, '1, rtl_pkg::RTL_GAIN_THR_RST);
    rdm(rtl_pkg::RTL_GAIN_WIN_OFS, '1, rtl_pkg::RTL_GAIN_WIN_RST);
    rdm(rtl_pkg::RTL_FREQ_CFG_OFS, '1, rtl_pkg::RTL_FREQ_CFG_RST);
    rdm(rtl_pkg::RTL_TIMING_CFG_OFS, '1, rtl_pkg::RTL_TIMING_CFG_RST);
    wr(8'h04, '1);
    rdm(8'h04, '1, 32'h0000_00ff);
    wr(8'h08, '1);
    rdm(8'h08, '1, 32'h0000_000f);
    wr(8'h10, '1);
    rdm(8'h10, '1, 32'h0000_01f7);
    wr(8'h20, 32'h1);
    `CHK("slverr", 1'b1, e)
    $display("registers done");
    // Gain loop: rise, window length, floor, ceiling, freeze
    wr(8'h04, 32'h0000_00c4);
    wr(8'h08, 32'h0);
    lvl <= 5'd17;
    wr(8'h00, 32'h1);
    agap(g);
    `CHK("win12", 12, g)
    tick(150);
    `CHK("atten", 4'h5, atten_o)
    wr(8'h08, 32'h2);
    lvl <= 5'd0;
    agap(g);
    `CHK("win48", 48, g)
    tick(400);
    `CHK("atten", 4'h0, atten_o)
    wr(8'h08, 32'h0);
    lvl <= 5'd31;
    tick(200);
    `CHK("atten", 4'h8, atten_o)
    rdm(rtl_pkg::RTL_STATUS_OFS, 32'hf, 32'h8);
    wr(8'h00, 32'h0);
    lvl <= 5'd0;
    tick(100);
    `CHK("atten", 4'h8, atten_o)
    wr(8'h04, 32'h0000_00f0);
    wr(8'h00, 32'h1);
    tick(100);
    `CHK("atten", 4'h8, atten_o)
    wr(8'h04, 32'h0000_00f1);
    tick(200);
    `CHK("atten", 4'h0, atten_o)
    lvl <= 5'd31;
    tick(100);
    `CHK("atten", 4'h0, atten_o)
    $display("gain loop done");
    // Each modulation, then disabled; hold off so sync changes nothing
    for (int m = 0; m < 5; m++) begin
      wr(8'h0c, m == 4 ? 32'h0043_4204 : 32'h0043_4205 | (32'(m) << 4));
      rx <= 1'b1;
      tick(10);
      rdm(8'h14, 32'h300, m < 3 ? 32'h100 : 32'h0);
      strobes(2);
      rdm(8'h14, 32'h300, m < 3 ? 32'h100 : 32'h0);
      strobes(3);
      sync_pulse();
      rdm(8'h14, 32'h300, m < 3 ? 32'h300 : 32'h0);
      `CHK("corr0", 1'(m >= 3), freq_corr_o == 12'sh000)
      rx <= 1'b0;
      tick(10);
    end
    cf[0] = 32'h0043_4207;
    cf[1] = 32'h0043_4203;
    for (int h = 0; h < 2; h++) begin
      wr(8'h0c, cf[h]);
      rx <= 1'b1;
      strobes(7);
      sync_pulse();
      rdm(8'h14, 32'h300, h == 0 ? 32'h200 : 32'h300);
      g = 32'(freq_corr_o);
      tick(100);
      `CHK("frozen", 1'(h == 0), g == 32'(freq_corr_o))
      rx <= 1'b0;
      tick(10);
    end
    $display("frequency loop done");
    // Phase loop learns a slow bit rate and keeps it without edges
    wr(8'h10, 32'h0000_0122);
    ep <= 8'd18;
    tick(3000);
    apb(8'h1c, 1'b0, 32'h0);
    `CHK("period", 1'b1, q >= 17 && q <= 19)
    ep <= 8'd0;
    tick(100);
    strobes(1);
    g = cyc;
    strobes(1);
    `CHK("hold", 1'b1, cyc - g >= 17 && cyc - g <= 19)
    // Gain 1 can take back the two-cycle slip at each edge
    wr(8'h10, 32'h0000_0001);
    ep <= 8'd18;
    tick(200);
    strobes(1);
    g = cyc;
    strobes(10);
    `CHK("dll", 1'b1, cyc - g >= 170 && cyc - g <= 190)
    ep <= 8'd0;
    tick(100);
    strobes(1);
    g = cyc;
    strobes(1);
    `CHK("nominal", 16, cyc - g)
    $display("timing loop done");
    wrap_up();
  end
endmodule : tb_rtl_tracking_loops
